// [core/atss_pkg.sv]
/*
 * atss_pkg: constants and carrier types for the converter trigger
 * source selector. Assumes a 32-bit AXI4-Lite register bus.
 */
package atss_pkg;
   // register map, byte addresses of the four selection words
   localparam logic [7:0] ATSS_SEL_BASE = 8'h00;
   localparam int ATSS_NUM_REGS = 4;
   localparam logic [15:0] ATSS_SEL_RESET = 16'h0000;
   // field positions
   localparam int ATSS_LO_LSB = 0;
   localparam int ATSS_HI_LSB = 8;
   localparam int ATSS_CODE_W = 5;
   localparam logic [15:0] ATSS_IMPL_MASK = 16'h1f1f;
   // selector encodings
   localparam logic [4:0] ATSS_C_NONE = 5'h00;
   localparam logic [4:0] ATSS_C_SW_COMMON = 5'h01;
   localparam logic [4:0] ATSS_C_SW_LEVEL = 5'h02;
   localparam logic [4:0] ATSS_C_PWM_SEV = 5'h04;
   localparam logic [4:0] ATSS_C_PG1_PRI = 5'h05;
   localparam logic [4:0] ATSS_C_PG2_PRI = 5'h06;
   localparam logic [4:0] ATSS_C_PG3_PRI = 5'h07;
   localparam logic [4:0] ATSS_C_TMR1 = 5'h0c;
   localparam logic [4:0] ATSS_C_TMR2 = 5'h0d;
   localparam logic [4:0] ATSS_C_PWM_SEV2 = 5'h0e;
   localparam logic [4:0] ATSS_C_PG1_SEC = 5'h0f;
   localparam logic [4:0] ATSS_C_PG2_SEC = 5'h10;
   localparam logic [4:0] ATSS_C_PG3_SEC = 5'h11;
   localparam logic [4:0] ATSS_C_OC1 = 5'h16;
   localparam logic [4:0] ATSS_C_PG1_CL = 5'h18;
   localparam logic [4:0] ATSS_C_PG2_CL = 5'h19;
   localparam logic [4:0] ATSS_C_PG3_CL = 5'h1a;
   localparam logic [4:0] ATSS_C_EXT = 5'h1f;
   // bus responses
   localparam logic [1:0] ATSS_RESP_OKAY = 2'b00;
   localparam logic [1:0] ATSS_RESP_SLVERR = 2'b10;

   // on-chip event sources that a selector may pick
   typedef struct packed {
      logic sw_common;
      logic sw_level;
      logic pwm_sev;
      logic pwm_sev2;
      logic [2:0] pg_pri;
      logic [2:0] pg_sec;
      logic [2:0] pg_cl;
      logic tmr1;
      logic tmr2;
      logic oc1;
      logic ext;
   } atss_src_type;
endpackage

// [core/atss_top.sv]
/*
 * atss_top: four selection registers, each holding two 5-bit trigger
 * codes, and the per-input multiplexer that forwards the chosen event
 * to the conversion-start logic of analog inputs 0..15.
 * Assumes event sources on mclk_i except the external pin, which is
 * synchronised here. Registers reached over AXI4-Lite.
 * Assumes every event source is an active-high level, held at least
 * one clock so that the registered output can see it.
 * Assumes the bus master keeps one write and one read under way at most;
 * a second read waits on arready, which stays low; a second write is taken into the holders and waits there for bready.
 * Write address and write data are taken in either order; the response
 * follows one clock after both holders are full.
 * Read data follow one clock after the address is taken and stand until
 * rready; a new read address is refused meanwhile.
 * Unmapped or unaligned words answer with an error, read as zero and
 * are never written.
 * Byte lanes 0 and 1 reach the low and high selector; lanes 2 and 3
 * carry nothing and are ignored.
 * Reserved codes and the all-zero code give no start at all, so an
 * input never fires from a code that software should not write.
 * Trigger outputs are registered, one clock after the event; the pin
 * path adds two more clocks of synchroniser delay.
 * Inputs 4x and 4x+1 belong to other selection words and stay low here.
 */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module atss_top
   import atss_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // event sources
   input wire atss_src_type src_i,
   input wire logic external_conversion_trigger_pin_i,
   // one conversion-start request per analog input
   output logic [4*ATSS_NUM_REGS-1:0] conv_start_o
);

   // selector word index from a byte address, or 4 when unmapped
   function automatic logic [2:0] atss_decode(input logic [7:0] addr);
      logic [2:0] idx;
      idx = 3'h4;
      if (addr[1:0] == 2'b00 && addr[7:4] == ATSS_SEL_BASE[7:4])
      begin
         idx = {1'b0, addr[3:2]};
      end
      return idx;
   endfunction

   // event picked by one code; reserved codes give nothing
   function automatic logic atss_pick(input logic [4:0] code, input atss_src_type s,
                                      input logic ext);
      logic hit;
      hit = 1'b0;
      case (code)
         ATSS_C_NONE: hit = 1'b0;
         ATSS_C_SW_COMMON: hit = s.sw_common;
         ATSS_C_SW_LEVEL: hit = s.sw_level;
         ATSS_C_PWM_SEV: hit = s.pwm_sev;
         ATSS_C_PWM_SEV2: hit = s.pwm_sev2;
         ATSS_C_PG1_PRI: hit = s.pg_pri[0];
         ATSS_C_PG2_PRI: hit = s.pg_pri[1];
         ATSS_C_PG3_PRI: hit = s.pg_pri[2];
         ATSS_C_PG1_SEC: hit = s.pg_sec[0];
         ATSS_C_PG2_SEC: hit = s.pg_sec[1];
         ATSS_C_PG3_SEC: hit = s.pg_sec[2];
         ATSS_C_PG1_CL: hit = s.pg_cl[0];
         ATSS_C_PG2_CL: hit = s.pg_cl[1];
         ATSS_C_PG3_CL: hit = s.pg_cl[2];
         ATSS_C_TMR1: hit = s.tmr1;
         ATSS_C_TMR2: hit = s.tmr2;
         ATSS_C_OC1: hit = s.oc1;
         ATSS_C_EXT: hit = ext;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // one byte lane of a write: masked new bits where strobed, old kept otherwise
   function automatic logic [7:0] atss_lane(input logic strobe, input logic [7:0] wbyte,
                                            input logic [7:0] keep, input logic [7:0] mask);
      logic [7:0] merged;
      merged = keep;
      if (strobe)
      begin
         merged = wbyte & mask;
      end
      return merged;
   endfunction

   logic [15:0] sel_r [ATSS_NUM_REGS];
   logic aw_full_r;
   logic [7:0] aw_addr_r;
   logic w_full_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic ext_meta_r;
   logic ext_sync_r;
   logic [4*ATSS_NUM_REGS-1:0] conv_r;
   wire logic [4*ATSS_NUM_REGS-1:0] conv_nxt;

   // handshake strobes, one per channel
   wire logic aw_take = s_axi_awvalid_i && !aw_full_r;
   wire logic w_take = s_axi_wvalid_i && !w_full_r;
   wire logic b_done = bvalid_r && s_axi_bready_i;
   wire logic r_done = rvalid_r && s_axi_rready_i;
   // write path decode
   wire logic wr_go = aw_full_r && w_full_r && !bvalid_r;
   wire logic [2:0] wr_idx = atss_decode(aw_addr_r);
   wire logic wr_hit = !wr_idx[2];
   wire logic [15:0] wr_old = sel_r[wr_idx[1:0]];
   // read path decode
   wire logic [2:0] rd_idx = atss_decode(s_axi_araddr_i);
   wire logic rd_go = s_axi_arvalid_i && !rvalid_r;
   wire logic [15:0] rd_word = rd_idx[2] ? 16'h0000 : sel_r[rd_idx[1:0]];
   // merged write value; unimplemented bits stay zero
   wire logic [7:0] wr_lo = atss_lane(w_strb_r[0], w_data_r[7:0], wr_old[7:0],
                                      ATSS_IMPL_MASK[7:0]);
   wire logic [7:0] wr_hi = atss_lane(w_strb_r[1], w_data_r[15:8], wr_old[15:8],
                                      ATSS_IMPL_MASK[15:8]);

   assign s_axi_awready_o = !aw_full_r;
   assign s_axi_wready_o = !w_full_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_arready_o = !rvalid_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign conv_start_o = conv_r;

   // write address holder flag, set when taken, cleared by the write
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         aw_full_r <= 1'b0;
      end
      else if (aw_take)
      begin
         aw_full_r <= 1'b1;
      end
      else if (wr_go)
      begin
         aw_full_r <= 1'b0;
      end
   end

   // write address payload
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         aw_addr_r <= 8'h00;
      end
      else if (aw_take)
      begin
         aw_addr_r <= s_axi_awaddr_i;
      end
   end

   // write data holder flag, taken in either order with the address
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         w_full_r <= 1'b0;
      end
      else if (w_take)
      begin
         w_full_r <= 1'b1;
      end
      else if (wr_go)
      begin
         w_full_r <= 1'b0;
      end
   end

   // write data payload and lane strobes
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end
      else if (w_take)
      begin
         w_data_r <= s_axi_wdata_i;
         w_strb_r <= s_axi_wstrb_i;
      end
   end

   // write response valid, stands until bready
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         bvalid_r <= 1'b0;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
      end
      else if (b_done)
      begin
         bvalid_r <= 1'b0;
      end
   end

   // write response code, error for unmapped words
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         bresp_r <= ATSS_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bresp_r <= wr_hit ? ATSS_RESP_OKAY : ATSS_RESP_SLVERR;
      end
   end

   // selection registers, cleared at reset
   generate
      for (genvar g = 0; g < ATSS_NUM_REGS; g++)
      begin : g_sel
         always_ff @(posedge mclk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               sel_r[g] <= ATSS_SEL_RESET;
            end
            else if (wr_go && wr_hit && wr_idx[1:0] == 2'(g))
            begin
               sel_r[g] <= {wr_hi[7:0], wr_lo[7:0]};
            end
         end
      end
   endgenerate

   // read valid, one cycle after address taken, stands until rready
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rvalid_r <= 1'b0;
      end
      else if (rd_go)
      begin
         rvalid_r <= 1'b1;
      end
      else if (r_done)
      begin
         rvalid_r <= 1'b0;
      end
   end

   // read data and code, unused bits forced to zero
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_r <= 32'h0000_0000;
         rresp_r <= ATSS_RESP_OKAY;
      end
      else if (rd_go)
      begin
         rdata_r <= {16'h0000, rd_word & ATSS_IMPL_MASK};
         rresp_r <= rd_idx[2] ? ATSS_RESP_SLVERR : ATSS_RESP_OKAY;
      end
   end

   // external pin synchroniser
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
      end
      else
      begin
         ext_meta_r <= external_conversion_trigger_pin_i;
         ext_sync_r <= ext_meta_r;
      end
   end

   // per-input selection: upper code to 4x+3, lower code to 4x+2
   generate
      for (genvar x = 0; x < ATSS_NUM_REGS; x++)
      begin : g_pick
         wire logic [4:0] hi_code = sel_r[x][ATSS_HI_LSB +: ATSS_CODE_W];
         wire logic [4:0] lo_code = sel_r[x][ATSS_LO_LSB +: ATSS_CODE_W];
         // inputs 4x and 4x+1 are served by other selection words
         assign conv_nxt[4*x+1 -: 2] = 2'b00;
         assign conv_nxt[4*x+3] = atss_pick(hi_code, src_i, ext_sync_r);
         assign conv_nxt[4*x+2] = atss_pick(lo_code, src_i, ext_sync_r);
      end
   endgenerate

   // registered trigger outputs
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         conv_r <= '0;
      end
      else
      begin
         conv_r <= conv_nxt;
      end
   end

endmodule

// [tb/atss_top_asserts.sv]
/* atss_top_asserts: read bus and trigger checks on atss_top ports.
   bound into atss_top; one clock, async active-low reset. */
`timescale 1ns/1ps
module atss_top_asserts
   import atss_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire atss_src_type src_i,
   input wire logic external_conversion_trigger_pin_i,
   input wire logic [4*ATSS_NUM_REGS-1:0] conv_start_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);
   // read taken, address kinds, quiet sources
   sequence s_ar; s_axi_arvalid_i && s_axi_arready_o; endsequence
   sequence s_bad; s_ar ##0 (s_axi_araddr_i > 8'h0c || s_axi_araddr_i[1:0] != 2'h0); endsequence
   sequence s_idle; src_i == '0 && !external_conversion_trigger_pin_i; endsequence
   property p_rd_lat; s_ar |=> s_axi_rvalid_o; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read late");
   property p_bad; s_bad |=> s_axi_rresp_o == ATSS_RESP_SLVERR && s_axi_rdata_o == 32'h0; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read");
   sequence s_good; s_ar ##0 (s_axi_araddr_i <= 8'h0c && s_axi_araddr_i[1:0] == 2'h0); endsequence
   property p_good; s_good |=> s_axi_rresp_o == ATSS_RESP_OKAY; endproperty
   a_good: assert property (p_good) else $error("mapped read refused");
   property p_pad; s_axi_rvalid_o |-> (s_axi_rdata_o & 32'hffffe0e0) == 32'h0; endproperty
   a_pad: assert property (p_pad) else $error("unused bits set");
   property p_rdone; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
   a_rdone: assert property (p_rdone) else $error("read held");
   property p_rbusy; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
   a_rbusy: assert property (p_rbusy) else $error("read overlap");
   property p_pairs; (conv_start_o & 16'h3333) == 16'h0; endproperty
   a_pairs: assert property (p_pairs) else $error("start on unserved input");
   property p_quiet; s_idle [*3] |=> conv_start_o == 16'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("start without event");
endmodule
bind atss_top atss_top_asserts i_atss_top_asserts (.*);

// [tb/atss_src_model.sv]
/* atss_src_model: on-chip event sources and trigger pin.
   random levels each rising edge while enabled, quiet otherwise. */
`timescale 1ns/1ps
module atss_src_model
   import atss_pkg::*;
(
   input wire logic mclk_i,
   input wire logic en_i,
   output atss_src_type src_o,
   output logic pin_o
);
   // fresh events after every rising edge
   initial
   begin
      src_o = '0;
      pin_o = '0;
   end
   always @(posedge mclk_i)
   begin
      src_o <= en_i ? atss_src_type'($urandom) : '0;
      pin_o <= en_i ? 1'($urandom) : '0;
   end
endmodule

// [tb/atss_top_test.sv]
/* atss_top_test: register, lane and routing bench for atss_top.
   atss_src_model drives the events; 50 MHz clock. */
`timescale 1ns/1ps
module atss_top_test
   import atss_pkg::*;
;
   logic clk = '0, rstn = '0, en = '0, p1 = '0, p2 = '0, p3 = '0;
   logic awv = '0, wv = '0, br = '0, arv = '0, rr = '0;
   logic [7:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, q, d, rdat;
   logic [3:0] ws = '0;
   logic [1:0] bresp, rresp, r;
   logic awr, wr_, bv, arr, rv, pin;
   logic [15:0] conv;
   logic [15:0] m [4];
   atss_src_type src, sd;
   int err_count = 0, total_checks = 0;
   // device and event sources
   atss_top i_atss_top (.mclk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
      .src_i(src), .external_conversion_trigger_pin_i(pin), .conv_start_o(conv));
   atss_src_model i_atss_src_model (.mclk_i(clk), .en_i(en), .src_o(src), .pin_o(pin));
   // clock and sampled event history
   initial forever #10 clk = ~clk;
   always @(posedge clk)
   begin
      sd <= src;
      {p3, p2, p1} <= {p2, p1, pin};
   end
   // event chosen by one selector code
   function automatic logic pick(input logic [4:0] c);
      case (c)
         5'h01: return sd.sw_common;
         5'h02: return sd.sw_level;
         5'h04: return sd.pwm_sev;
         5'h0e: return sd.pwm_sev2;
         5'h05, 5'h06, 5'h07: return sd.pg_pri[c - 5'h05];
         5'h0f, 5'h10, 5'h11: return sd.pg_sec[c - 5'h0f];
         5'h18, 5'h19, 5'h1a: return sd.pg_cl[c - 5'h18];
         5'h0c: return sd.tmr1;
         5'h0d: return sd.tmr2;
         5'h16: return sd.oc1;
         5'h1f: return p3;
         default: return '0;
      endcase
   endfunction
   // expected start word from the mirror
   function automatic logic [15:0] exp_conv();
      logic [15:0] e;
      e = '0;
      for (int x = 0; x < 4; x++)
      begin
         e[4*x+3] = pick(m[x][12:8]);
         e[4*x+2] = pick(m[x][4:0]);
      end
      return e;
   endfunction
   // compare and count
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] want);
      total_checks++;
      if (got !== want)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, want, got);
      end
   endtask
   // verdict, then stop
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one bus transfer, each channel held until taken
   task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] dv,
      input logic [3:0] s);
      bit ta, tw, tr, dn;
      @(posedge clk);
      awa <= a;
      ara <= a;
      wd <= dv;
      ws <= s;
      awv <= w;
      wv <= w;
      br <= w;
      arv <= !w;
      rr <= !w;
      for (int n = 0; n < 64; n++)
      begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr_;
         tr = arv & arr;
         dn = w ? bv : rv;
         q = rdat;
         r = w ? bresp : rresp;
         @(posedge clk);
         awv <= awv & !ta;
         wv <= wv & !tw;
         arv <= arv & !tr;
         br <= br & !dn;
         rr <= rr & !dn;
         if (dn)
            return;
      end
      err_count++;
      report_and_stop();
   endtask
   // mirror of a write, unused bits dropped
   task automatic upd(input int x);
      if (ws[0])
         m[x][7:0] = wd[7:0] & 8'h1f;
      if (ws[1])
         m[x][15:8] = wd[15:8] & 8'h1f;
   endtask
   // reset, then every register reads zero
   task automatic rst_read();
      @(posedge clk);
      rstn <= '0;
      repeat (2) @(posedge clk);
      rstn <= '1;
      for (int x = 0; x < 4; x++)
      begin
         m[x] = ATSS_SEL_RESET;
         xfer(0, 8'(4*x), 32'h0, 4'h0);
         chk("reset", q, 32'h0);
         chk("rresp_ok", r, ATSS_RESP_OKAY);
      end
   endtask
   // main sequence
   initial
   begin
      void'($urandom(32'h06c7));
      rst_read();
      // byte lanes: low, high, both, lane 2 alone
      for (int x = 0; x < 4; x++)
      begin
         xfer(1, 8'(4*x), 32'hffffffff, 4'(x + 1));
         chk("bresp_ok", r, ATSS_RESP_OKAY);
         upd(x);
         xfer(0, 8'(4*x), 32'h0, 4'h0);
         chk("lanes", q, {16'h0, m[x]});
      end
      // unmapped places answer with an error
      xfer(1, 8'h10, 32'hffffffff, 4'hf);
      chk("wresp", r, ATSS_RESP_SLVERR);
      xfer(0, 8'h02, 32'h0, 4'h0);
      chk("rresp", r, ATSS_RESP_SLVERR);
      // every code in both fields against random events
      en <= '1;
      for (int c = 0; c < 32; c++)
      begin
         for (int x = 0; x < 4; x++)
         begin
            d = $urandom;
            d[12:8] = 5'(c + 2 * x + 1);
            d[4:0] = 5'(c + 2 * x);
            xfer(1, 8'(4*x), d, 4'h3);
            upd(x);
         end
         repeat (8)
         begin
            @(negedge clk);
            chk("conv", conv, exp_conv());
         end
      end
      en <= '0;
      rst_read();
      report_and_stop();
   end
endmodule
